/* hw/serial_channel_options.sv */
// option logic of one asynchronous serial channel: flow control, loopback, modem gating
// assumes a character transmitter and receiver core beside it and an apb master
//
// Function
// - implied resume restarts on any good character except the stop char
// - implied resume inert without in-band flow
// - compare good received chars with stop char
// - stop only after loaded characters finish
// - resume on resume char or enable command
// - execute embedded commands from transmit fifo
// - local loopback feeds transmitter into receiver
// - local loopback holds txd marking
// - remote loopback echoes received characters
// - auto rts asserts when enabled with data
// - auto rts negates when disabled or empty
// - auto cts blocks transmit start
// - auto dsr discards received characters
// - in-band flow needs special match enabled
// - transparency keeps flow chars out of fifo
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps

module serial_channel_options
  import serial_opt_pkg::*;
#(
  parameter int CHAR_W = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_char_valid,
  input wire logic [7:0] tx_char_data,
  output logic tx_char_pop,
  input wire logic xmit_ready,
  input wire logic xmit_idle,
  output logic xmit_load,
  output logic [7:0] xmit_data,
  input wire logic core_txd,
  output logic core_rxd,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_char_error,
  output logic rx_store_valid,
  output logic [7:0] rx_store_data,
  output logic rx_exception,
  output logic embedded_cmd_valid,
  output logic [7:0] embedded_cmd_code,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  input wire logic dsr_n,
  output logic rts_n
);

  if (CHAR_W != 8)
  begin : g_width_check
    $error("serial_channel_options serves 8-bit characters only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave and registers

  logic [7:0] channel_option_two_reg, channel_option_two_next;
  logic [7:0] channel_option_three_reg, channel_option_three_next;
  logic [7:0] special_char_one_reg, special_char_one_next;
  logic [7:0] special_char_two_reg, special_char_two_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [5:0] reg_idx;
  logic mapped;
  logic wr_fire;
  logic cmd_write;
  logic [7:0] status_byte;

  logic tx_en_reg, rx_en_reg, stopped_reg, echo_pend_reg;
  logic [7:0] echo_data_reg;

  assign reg_idx = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'b00) && (reg_idx == IDX_OPTION_TWO ||
    reg_idx == IDX_OPTION_THREE || reg_idx == IDX_SPECIAL_ONE ||
    reg_idx == IDX_SPECIAL_TWO || reg_idx == IDX_COMMAND || reg_idx == IDX_STATUS);
  assign wr_fire = psel && penable && pready_reg && pwrite && mapped;
  assign cmd_write = wr_fire && (reg_idx == IDX_COMMAND);

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[BIT_ST_STOPPED] = stopped_reg;
    status_byte[BIT_ST_TX_EN] = tx_en_reg;
    status_byte[BIT_ST_RX_EN] = rx_en_reg;
    status_byte[BIT_ST_RTS] = !rts_n;
    status_byte[BIT_ST_CTS] = !cts_n;
    status_byte[BIT_ST_DSR] = !dsr_n;
    status_byte[BIT_ST_ECHO] = echo_pend_reg;
  end

  // zero wait state: the answer is prepared during the setup cycle
  always_comb
  begin
    pready_next = psel && !penable;
    pslverr_next = psel && !penable && !mapped;
    prdata_next = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      unique case (reg_idx)
        IDX_OPTION_TWO: prdata_next = {24'h000000, channel_option_two_reg};
        IDX_OPTION_THREE: prdata_next = {24'h000000, channel_option_three_reg};
        IDX_SPECIAL_ONE: prdata_next = {24'h000000, special_char_one_reg};
        IDX_SPECIAL_TWO: prdata_next = {24'h000000, special_char_two_reg};
        IDX_STATUS: prdata_next = {24'h000000, status_byte};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
    channel_option_two_next = channel_option_two_reg;
    channel_option_three_next = channel_option_three_reg;
    special_char_one_next = special_char_one_reg;
    special_char_two_next = special_char_two_reg;
    if (wr_fire)
    begin
      if (reg_idx == IDX_OPTION_TWO)
        channel_option_two_next = pwdata[7:0];
      if (reg_idx == IDX_OPTION_THREE)
        channel_option_three_next = pwdata[7:0];
      if (reg_idx == IDX_SPECIAL_ONE)
        special_char_one_next = pwdata[7:0];
      if (reg_idx == IDX_SPECIAL_TWO)
        special_char_two_next = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_option_two_reg <= OPTION_TWO_RESET;
      channel_option_three_reg <= OPTION_THREE_RESET;
      special_char_one_reg <= SPECIAL_RESET;
      special_char_two_reg <= SPECIAL_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      channel_option_two_reg <= channel_option_two_next;
      channel_option_three_reg <= channel_option_three_next;
      special_char_one_reg <= special_char_one_next;
      special_char_two_reg <= special_char_two_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option decode

  logic implied_resume_any_char, auto_inband_tx_flow_en, embedded_tx_command_en;
  logic local_loopback_en, remote_echo_loopback_en, auto_request_to_send_out;
  logic auto_clear_to_send_gate, auto_data_set_ready_gate;
  logic flow_char_transparency, match_one_two_en, flow_on;

  assign implied_resume_any_char = channel_option_two_reg[BIT_IMPLIED_RESUME];
  assign auto_inband_tx_flow_en = channel_option_two_reg[BIT_INBAND_FLOW];
  assign embedded_tx_command_en = channel_option_two_reg[BIT_EMBEDDED_CMD];
  assign local_loopback_en = channel_option_two_reg[BIT_LOCAL_LOOP];
  assign remote_echo_loopback_en = channel_option_two_reg[BIT_REMOTE_ECHO];
  assign auto_request_to_send_out = channel_option_two_reg[BIT_AUTO_RTS];
  assign auto_clear_to_send_gate = channel_option_two_reg[BIT_AUTO_CTS];
  assign auto_data_set_ready_gate = channel_option_two_reg[BIT_AUTO_DSR];
  assign flow_char_transparency = channel_option_three_reg[BIT_FLOW_TRANSPARENT];
  assign match_one_two_en = channel_option_three_reg[BIT_MATCH_ONE_TWO];
  assign flow_on = auto_inband_tx_flow_en && match_one_two_en;

  ////////////////////////////////////////////////////////////////////////////
  // receive side: gating, matching, flow state, echo capture

  logic rx_accept, rx_good, hit_stop, hit_resume, flow_char, keep_char;
  logic chan_enable_cmd, tx_ok, take_echo, fifo_turn, cmd_take, data_take;
  logic consume;
  logic tx_en_next, rx_en_next, stopped_next, echo_pend_next;
  logic [7:0] echo_data_next;

  assign rx_accept = rx_char_valid && !(auto_data_set_ready_gate && dsr_n);
  assign rx_good = rx_accept && !rx_char_error;
  assign hit_stop = flow_on && rx_good && (rx_char_data == special_char_two_reg);
  assign hit_resume = flow_on && rx_good &&
    ((rx_char_data == special_char_one_reg) || implied_resume_any_char);
  assign flow_char = match_one_two_en && rx_good &&
    ((rx_char_data == special_char_one_reg) || (rx_char_data == special_char_two_reg));
  assign keep_char = rx_accept && !(flow_char_transparency && flow_on && flow_char);
  assign chan_enable_cmd = cmd_write && (pwdata[BIT_CMD_TX_EN] || pwdata[BIT_CMD_RX_EN]);

  always_comb
  begin
    tx_en_next = tx_en_reg;
    rx_en_next = rx_en_reg;
    if (cmd_write)
    begin
      if (pwdata[BIT_CMD_TX_EN])
        tx_en_next = 1'b1;
      else if (pwdata[BIT_CMD_TX_DIS])
        tx_en_next = 1'b0;
      if (pwdata[BIT_CMD_RX_EN])
        rx_en_next = 1'b1;
      else if (pwdata[BIT_CMD_RX_DIS])
        rx_en_next = 1'b0;
    end
    // a stop arriving with a resume event wins, so the peer's stop is never lost
    stopped_next = stopped_reg;
    if (hit_stop)
      stopped_next = 1'b1;
    else if (hit_resume || chan_enable_cmd)
      stopped_next = 1'b0;
    // one echo slot: a character arriving before the last one left overwrites it
    echo_pend_next = echo_pend_reg && !take_echo;
    echo_data_next = echo_data_reg;
    if (remote_echo_loopback_en && rx_accept)
    begin
      echo_pend_next = 1'b1;
      echo_data_next = rx_char_data;
    end
    else if (!remote_echo_loopback_en)
      echo_pend_next = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit side: loader, pins, rts

  tx_cmd_parser u_parser (
    .pclk(pclk),
    .presetn(presetn),
    .enable(embedded_tx_command_en),
    .head_data(tx_char_data),
    .take(cmd_take || data_take),
    .consume(consume),
    .cmd_valid(embedded_cmd_valid),
    .cmd_code(embedded_cmd_code)
  );

  // the loaded character leaves xmit_ready low a cycle late, so no load back to back
  assign tx_ok = tx_en_reg && xmit_ready && !xmit_load &&
    !(auto_clear_to_send_gate && cts_n);
  assign take_echo = echo_pend_reg && tx_ok;
  // stop only blocks new fifo loads; holding and shift contents drain normally
  assign fifo_turn = tx_char_valid && !tx_char_pop && !remote_echo_loopback_en &&
    !stopped_reg && !echo_pend_reg;
  assign cmd_take = fifo_turn && consume && tx_en_reg;
  assign data_take = fifo_turn && !consume && tx_ok;

  logic tx_pop_next, load_next, txd_next, core_rxd_next, rts_n_next;
  logic [7:0] xmit_data_next;
  logic store_next, exc_next;

  always_comb
  begin
    tx_pop_next = cmd_take || data_take;
    load_next = take_echo || data_take;
    xmit_data_next = take_echo ? echo_data_reg : tx_char_data;
    txd_next = local_loopback_en ? 1'b1 : core_txd;
    core_rxd_next = local_loopback_en ? core_txd : rxd;
    rts_n_next = !(auto_request_to_send_out && (tx_en_reg || rx_en_reg) &&
      (tx_char_valid || !xmit_idle || xmit_load));
    store_next = keep_char;
    exc_next = keep_char && flow_char;
  end

  logic tx_pop_reg, load_reg, txd_reg, core_rxd_reg, rts_n_reg, store_reg, exc_reg;
  logic [7:0] xmit_data_reg, store_data_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_en_reg <= 1'b0;
      rx_en_reg <= 1'b0;
      stopped_reg <= 1'b0;
      echo_pend_reg <= 1'b0;
      echo_data_reg <= 8'h00;
      tx_pop_reg <= 1'b0;
      load_reg <= 1'b0;
      xmit_data_reg <= 8'h00;
      txd_reg <= 1'b1;
      core_rxd_reg <= 1'b1;
      rts_n_reg <= 1'b1;
      store_reg <= 1'b0;
      store_data_reg <= 8'h00;
      exc_reg <= 1'b0;
    end
    else
    begin
      tx_en_reg <= tx_en_next;
      rx_en_reg <= rx_en_next;
      stopped_reg <= stopped_next;
      echo_pend_reg <= echo_pend_next;
      echo_data_reg <= echo_data_next;
      tx_pop_reg <= tx_pop_next;
      load_reg <= load_next;
      xmit_data_reg <= xmit_data_next;
      txd_reg <= txd_next;
      core_rxd_reg <= core_rxd_next;
      rts_n_reg <= rts_n_next;
      store_reg <= store_next;
      store_data_reg <= rx_char_data;
      exc_reg <= exc_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign tx_char_pop = tx_pop_reg;
  assign xmit_load = load_reg;
  assign xmit_data = xmit_data_reg;
  assign txd = txd_reg;
  assign core_rxd = core_rxd_reg;
  assign rts_n = rts_n_reg;
  assign rx_store_valid = store_reg;
  assign rx_store_data = store_data_reg;
  assign rx_exception = exc_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_resume_any_char: assert property (
    stopped_reg && flow_on && implied_resume_any_char && rx_good &&
    rx_char_data != special_char_two_reg |=> !stopped_reg)
    else $error("implied resume did not restart transmission");
  a_implied_inert: assert property (
    !flow_on && !cmd_write |=> $stable(stopped_reg))
    else $error("flow state moved without in-band flow control");
  a_stop_on_match: assert property (
    flow_on && rx_good && rx_char_data == special_char_two_reg |=> stopped_reg)
    else $error("stop character did not stop transmission");
  a_no_new_load: assert property (
    stopped_reg && !echo_pend_reg |=> !tx_char_pop)
    else $error("fifo popped while stopped");
  a_enable_resumes: assert property (
    chan_enable_cmd && !hit_stop |=> !stopped_reg)
    else $error("enable command did not resume");
  a_cmd_not_sent: assert property (
    embedded_tx_command_en && tx_char_valid && fifo_turn &&
    consume |=> !xmit_load)
    else $error("escape byte sent as data");
  a_local_to_rx: assert property (
    local_loopback_en |=> core_rxd == $past(core_txd))
    else $error("local loopback not routed to receiver");
  a_local_marking: assert property (
    local_loopback_en [*2] |-> txd)
    else $error("txd not marking in local loopback");
  a_echo_loaded: assert property (
    remote_echo_loopback_en && rx_accept && tx_ok ##1 remote_echo_loopback_en
    && tx_ok |=> xmit_load && xmit_data == $past(rx_char_data, 2))
    else $error("received character not echoed");
  a_rts_assert: assert property (
    auto_request_to_send_out && tx_en_reg && tx_char_valid |=> !rts_n)
    else $error("auto rts not asserted");
  a_rts_negate: assert property (
    !tx_en_reg && !rx_en_reg |=> rts_n)
    else $error("auto rts asserted while disabled");
  a_cts_blocks: assert property (
    auto_clear_to_send_gate && cts_n |=> !xmit_load)
    else $error("transmit started without cts");
  a_dsr_discard: assert property (
    auto_data_set_ready_gate && dsr_n |=> !rx_store_valid)
    else $error("character kept while dsr deasserted");
  a_needs_match: assert property (
    !match_one_two_en && !cmd_write |=> $stable(stopped_reg))
    else $error("flow control acted without special match");
  a_flow_hidden: assert property (
    flow_char_transparency && flow_on && flow_char |=> !rx_store_valid)
    else $error("flow character stored under transparency");

  c_stop_resume: cover property (hit_stop ##[1:20] hit_resume);
  c_echo: cover property (take_echo);
  c_embedded: cover property (embedded_cmd_valid);
  c_local_loop: cover property (local_loopback_en && xmit_load);

endmodule : serial_channel_options

/* hw/tx_cmd_parser.sv */
// embedded transmit command recogniser for the transmit fifo stream
// assumes the caller advances it with take only when the head byte leaves the fifo
`timescale 1ns/1ps

module tx_cmd_parser
  import serial_opt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [7:0] head_data,
  input wire logic take,
  output logic consume,
  output logic cmd_valid,
  output logic [7:0] cmd_code
);

  parse_state_t state_reg;
  parse_state_t state_next;
  logic cmd_valid_reg;
  logic cmd_valid_next;
  logic [7:0] cmd_code_reg;
  logic [7:0] cmd_code_next;

  // escape followed by escape sends one literal escape byte
  always_comb
  begin
    consume = 1'b0;
    state_next = state_reg;
    cmd_valid_next = 1'b0;
    cmd_code_next = cmd_code_reg;
    unique case (state_reg)
      PARSE_DATA:
      begin
        consume = enable && (head_data == EMBED_ESCAPE);
        if (take && consume)
        begin
          state_next = PARSE_CODE;
        end
      end
      PARSE_CODE:
      begin
        consume = (head_data != EMBED_ESCAPE);
        if (take)
        begin
          state_next = PARSE_DATA;
          cmd_valid_next = consume;
          cmd_code_next = head_data;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= PARSE_DATA;
      cmd_valid_reg <= 1'b0;
      cmd_code_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      cmd_valid_reg <= cmd_valid_next;
      cmd_code_reg <= cmd_code_next;
    end
  end

  assign cmd_valid = cmd_valid_reg;
  assign cmd_code = cmd_code_reg;

endmodule : tx_cmd_parser

/* inc/serial_opt_pkg.sv */
// register map, field positions and reset values of the serial channel option block
// assumes a 32-bit apb slave with one register per aligned word
package serial_opt_pkg;

  // printed register indices; byte address is four times the index
  localparam logic [5:0] IDX_OPTION_TWO = 6'h09;
  localparam logic [5:0] IDX_OPTION_THREE = 6'h0A;
  localparam logic [5:0] IDX_SPECIAL_ONE = 6'h10;
  localparam logic [5:0] IDX_SPECIAL_TWO = 6'h11;
  localparam logic [5:0] IDX_COMMAND = 6'h12;
  localparam logic [5:0] IDX_STATUS = 6'h13;

  localparam logic [7:0] OPTION_TWO_RESET = 8'h00;
  localparam logic [7:0] OPTION_THREE_RESET = 8'h00;
  localparam logic [7:0] SPECIAL_RESET = 8'h00;

  // option two fields
  localparam int BIT_IMPLIED_RESUME = 7;
  localparam int BIT_INBAND_FLOW = 6;
  localparam int BIT_EMBEDDED_CMD = 5;
  localparam int BIT_LOCAL_LOOP = 4;
  localparam int BIT_REMOTE_ECHO = 3;
  localparam int BIT_AUTO_RTS = 2;
  localparam int BIT_AUTO_CTS = 1;
  localparam int BIT_AUTO_DSR = 0;

  // option three fields used here
  localparam int BIT_FLOW_TRANSPARENT = 5;
  localparam int BIT_MATCH_ONE_TWO = 4;

  // command register fields
  localparam int BIT_CMD_TX_EN = 3;
  localparam int BIT_CMD_TX_DIS = 2;
  localparam int BIT_CMD_RX_EN = 1;
  localparam int BIT_CMD_RX_DIS = 0;

  // status register fields
  localparam int BIT_ST_STOPPED = 0;
  localparam int BIT_ST_TX_EN = 1;
  localparam int BIT_ST_RX_EN = 2;
  localparam int BIT_ST_RTS = 3;
  localparam int BIT_ST_CTS = 4;
  localparam int BIT_ST_DSR = 5;
  localparam int BIT_ST_ECHO = 6;

  // embedded command escape byte in the transmit stream
  localparam logic [7:0] EMBED_ESCAPE = 8'h00;

  typedef enum logic [0:0] {PARSE_DATA, PARSE_CODE} parse_state_t;

endpackage : serial_opt_pkg

/* tb/serial_channel_options_test.sv */
// self-checking bench for the serial channel option block
// assumes a zero-wait apb slave and a peer model on the modem lines
`timescale 1ns/1ps

module serial_channel_options_test;
  import serial_opt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0] paddr, xmit_data, rx_char_data, rx_store_data, embedded_cmd_code, cap;
  logic [31:0] pwdata, prdata, rdv;
  logic tx_char_pop, xmit_ready, xmit_idle, xmit_load, core_txd, core_rxd;
  logic rx_char_valid, rx_char_error, rx_store_valid, rx_exception, embedded_cmd_valid;
  logic rxd, txd, cts_n, dsr_n, rts_n, allow_send, ready_set, line_bit;
  logic [7:0] fq [0:15];
  logic [3:0] rp, wp;
  logic [4:0] ev;
  int n_fail, num_checks, cyc;

  // small transmit fifo in front of the block
  wire logic tx_char_valid = (rp != wp);
  wire logic [7:0] tx_char_data = fq[rp];
  assign ev = {rx_exception, embedded_cmd_valid, rx_store_valid, xmit_load, tx_char_pop};

  serial_channel_options u_serial_channel_options (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_char_valid(tx_char_valid),
    .tx_char_data(tx_char_data), .tx_char_pop(tx_char_pop), .xmit_ready(xmit_ready),
    .xmit_idle(xmit_idle), .xmit_load(xmit_load), .xmit_data(xmit_data),
    .core_txd(core_txd), .core_rxd(core_rxd), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_char_error(rx_char_error),
    .rx_store_valid(rx_store_valid), .rx_store_data(rx_store_data),
    .rx_exception(rx_exception), .embedded_cmd_valid(embedded_cmd_valid),
    .embedded_cmd_code(embedded_cmd_code), .rxd(rxd), .txd(txd), .cts_n(cts_n),
    .dsr_n(dsr_n), .rts_n(rts_n));

  serial_peer u_serial_peer (.pclk(pclk), .allow_send(allow_send), .ready_set(ready_set),
    .line_bit(line_bit), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; holds the request until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdv = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rx(input logic [7:0] d);
    @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
  endtask : rx

  task push(input logic [7:0] d);
    @(posedge pclk);
    fq[wp] <= d;
    wp <= wp + 4'h1;
  endtask : push

  // pulses last one cycle, so every edge of the window is looked at
  task watch(input int b, input logic exp);
    logic s;
    s = 1'b0;
    repeat (12)
    begin
      @(posedge pclk);
      s = s | ev[b];
      if (rx_store_valid === 1'b1)
        cap = rx_store_data;
      if (xmit_load === 1'b1)
        cap = xmit_data;
      if (embedded_cmd_valid === 1'b1)
        cap = embedded_cmd_code;
    end
    chk(s, exp);
  endtask : watch

  always @(posedge pclk)
  begin
    if (tx_char_pop === 1'b1)
      rp <= rp + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_char_valid, rx_char_data, rx_char_error, rp, wp, cap} = '0;
    {xmit_ready, xmit_idle, core_txd, line_bit, allow_send, ready_set} = 6'h3F;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h24, 8'h00); chk(rdv, 32'h00000000);
    apb(1'b1, 8'h24, 8'hFF); apb(1'b0, 8'h24, 8'h00); chk(rdv, 32'h000000FF);
    apb(1'b0, 8'h30, 8'h00); chk(perr, 1'b1);
    apb(1'b1, 8'h28, 8'h10);
    apb(1'b1, 8'h40, 8'h11);
    apb(1'b1, 8'h44, 8'h13);
    apb(1'b1, 8'h48, 8'h0A);
    // loopback: drive opposite levels so a pass-through cannot hide
    apb(1'b1, 8'h24, 8'h10);
    core_txd <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(txd, 1'b1);
    chk(core_rxd, 1'b0);
    core_txd <= 1'b1;
    apb(1'b1, 8'h24, 8'h08); rx(8'h5A); watch(1, 1'b1); chk(cap, 8'h5A);
    apb(1'b1, 8'h24, 8'h00); rx(8'h66); watch(1, 1'b0);
    apb(1'b1, 8'h24, 8'h40); rx(8'h13); push(8'h41); watch(0, 1'b0);
    rx(8'h11); watch(0, 1'b1);
    rx(8'h13); push(8'h42); watch(0, 1'b0);
    apb(1'b1, 8'h48, 8'h08); watch(0, 1'b1);
    apb(1'b1, 8'h24, 8'hC0); rx(8'h13); push(8'h43); watch(0, 1'b0);
    rx(8'h20); watch(0, 1'b1);
    apb(1'b1, 8'h24, 8'h80); rx(8'h13); push(8'h47); watch(0, 1'b1);
    apb(1'b1, 8'h24, 8'h40); apb(1'b1, 8'h28, 8'h00);
    rx(8'h13); push(8'h46); watch(0, 1'b1);
    apb(1'b1, 8'h28, 8'h30); rx(8'h11); watch(2, 1'b0);
    apb(1'b1, 8'h28, 8'h10); rx(8'h11); watch(4, 1'b1);
    chk(cap, 8'h11);
    apb(1'b1, 8'h24, 8'h01);
    ready_set <= 1'b0;
    rx(8'h55); watch(2, 1'b0);
    ready_set <= 1'b1;
    rx(8'h55); watch(2, 1'b1);
    chk(cap, 8'h55);
    apb(1'b1, 8'h24, 8'h02);
    allow_send <= 1'b0;
    push(8'h44); watch(0, 1'b0);
    allow_send <= 1'b1;
    watch(0, 1'b1);
    // rts: hold the core busy so data stays pending
    apb(1'b1, 8'h24, 8'h04);
    xmit_ready <= 1'b0;
    xmit_idle <= 1'b0;
    push(8'h45);
    repeat (4) @(posedge pclk);
    chk(rts_n, 1'b0);
    apb(1'b1, 8'h48, 8'h05);
    repeat (3) @(posedge pclk);
    chk(rts_n, 1'b1);
    apb(1'b1, 8'h48, 8'h0A);
    xmit_ready <= 1'b1;
    watch(0, 1'b1);
    xmit_idle <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(rts_n, 1'b1);
    apb(1'b1, 8'h24, 8'h20); push(8'h00); push(8'h07); watch(3, 1'b1);
    chk(cap, 8'h07);
    give_verdict;
  end
endmodule : serial_channel_options_test

/* tb/serial_peer.sv */
// remote serial peer: drives the receive pin and the modem status lines
// assumes the bench changes its control inputs right after a rising edge
`timescale 1ns/1ps

module serial_peer
(
  input wire logic pclk,
  input wire logic allow_send,
  input wire logic ready_set,
  input wire logic line_bit,
  output logic rxd,
  output logic cts_n,
  output logic dsr_n
);
  // line rests at mark and modem lines start negated, as a cold peer would
  initial
  begin
    rxd = 1'b1;
    cts_n = 1'b1;
    dsr_n = 1'b1;
  end

  always @(posedge pclk)
  begin
    rxd <= line_bit;
    cts_n <= ~allow_send;
    dsr_n <= ~ready_set;
  end
endmodule : serial_peer
